// *** hdl/ioc_divider.sv ***
// dynamic divider of a tick stream, ratio may change at any time
// assumes tickIn is a one-cycle enable from logic on the same clock
`default_nettype none
module ioc_divider #(
	parameter int WIDTH = 12
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic tickIn,
	input wire logic [WIDTH-1:0] ratio,
	output logic tickOut
);
	logic [WIDTH-1:0] cnt_reg;
	logic [WIDTH-1:0] cnt_next;
	logic tick_reg;
	logic tick_next;

	// >= instead of == so a ratio cut mid-count wraps at once
	always_comb
	begin
		cnt_next = cnt_reg;
		tick_next = 1'b0;
		if (tickIn)
		begin
			if (cnt_reg >= ratio - WIDTH'(1))
			begin
				cnt_next = '0;
				tick_next = 1'b1;
			end
			else
				cnt_next = cnt_reg + WIDTH'(1);
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tickOut = tick_reg;

	AST_DIV_CAUSE: assert property (@(posedge clock) disable iff (rst)
		tickOut |-> $past(tickIn))
		else $error("divider tick without input tick");
endmodule
`default_nettype wire

// *** hdl/ioc_osc_control.sv ***
// internal oscillator control: source select, hf frequency, post divider,
// mid-frequency dividers, trim and converter oscillator enable
// assumes hfTick, lfTick and converter inputs come from same-clock logic;
// the reset select strap is a pin and is synchronised
//
// Implementation choices: the placing of the registers and the plain strobed port.
`default_nettype none
module ioc_osc_control (
	input wire logic clock,
	input wire logic rst,
	input wire logic [2:0] resetOscSelect,
	input wire logic hfTick,
	input wire logic lfTick,
	input wire logic converterSelectsRc,
	input wire logic [ioc_pkg::ADDR_W-1:0] addr,
	input wire logic [ioc_pkg::DATA_W-1:0] wrData,
	input wire logic wrStrobe,
	input wire logic rdStrobe,
	output logic [ioc_pkg::DATA_W-1:0] rdData,
	output logic [3:0] hfFreqSelect,
	output logic signed [5:0] hfTrimLevel,
	output logic sysClkTick,
	output logic [2:0] activeOsc,
	output logic lfSlowTick,
	output logic mfTick500k,
	output logic mfTick31k,
	output logic converterOscRun
);
	logic [2:0] strapMeta_reg;
	logic [2:0] strapSync_reg;
	ioc_pkg::ioc_state_e state_reg, state_next;
	logic [1:0] bootCnt_reg, bootCnt_next;
	logic [2:0] newOsc_reg, newOsc_next;
	logic [2:0] active_reg, active_next;
	logic [3:0] new_divider_select_reg, new_divider_select_next;
	logic [3:0] freq_reg, freq_next;
	logic [5:0] trim_reg, trim_next;
	logic convEn_reg, convEn_next;
	logic [ioc_pkg::DATA_W-1:0] rd_reg, rd_next;
	logic sysTick_reg, sysTick_next;
	logic lfTick_reg;
	logic [3:0] freqClamp;
	logic [3:0] ndivClamp;
	logic [ioc_pkg::DIV_W-1:0] postRatio;
	logic postTick;
	logic onHf;
	logic targetHf;
	logic selValid;

	// strap crosses in from a pin
	always_ff @(posedge clock)
	begin
		strapMeta_reg <= resetOscSelect;
		strapSync_reg <= strapMeta_reg;
	end

	// clamp codes instead of letting the table run off its end
	assign freqClamp = (freq_reg > ioc_pkg::FRQ_CODE_MAX) ?
		ioc_pkg::FRQ_CODE_MAX : freq_reg;
	assign ndivClamp = (new_divider_select_reg > ioc_pkg::NEW_DIVIDER_SELECT_MAX) ?
		ioc_pkg::NEW_DIVIDER_SELECT_MAX : new_divider_select_reg;
	assign postRatio = ioc_pkg::DIV_W'(12'h001 << ndivClamp);
	assign onHf = (active_reg != ioc_pkg::SEL_LF);
	assign targetHf = (newOsc_reg != ioc_pkg::SEL_LF);
	assign selValid = (wrData[6:4] == ioc_pkg::SEL_HF_1M)
		|| (wrData[6:4] == ioc_pkg::SEL_HF_64M)
		|| (wrData[6:4] == ioc_pkg::SEL_LF);

	always_comb
	begin
		state_next = state_reg;
		bootCnt_next = bootCnt_reg;
		newOsc_next = newOsc_reg;
		active_next = active_reg;
		new_divider_select_next = new_divider_select_reg;
		freq_next = freq_reg;
		trim_next = trim_reg;
		convEn_next = convEn_reg;
		case (state_reg)
			ioc_pkg::ST_BOOT:
			begin
				// wait until the strap synchroniser holds the pin level
				bootCnt_next = bootCnt_reg + 2'h1;
				if (bootCnt_reg == ioc_pkg::BOOT_WAIT)
				begin
					state_next = ioc_pkg::ST_RUN;
					if (strapSync_reg == ioc_pkg::SEL_LF)
					begin
						active_next = ioc_pkg::SEL_LF;
						newOsc_next = ioc_pkg::SEL_LF;
					end
					else if (strapSync_reg == ioc_pkg::SEL_HF_64M)
					begin
						active_next = ioc_pkg::SEL_HF_64M;
						newOsc_next = ioc_pkg::SEL_HF_64M;
						freq_next = ioc_pkg::FRQ_64MHZ;
					end
					else
					begin
						active_next = ioc_pkg::SEL_HF_1M;
						newOsc_next = ioc_pkg::SEL_HF_1M;
						freq_next = ioc_pkg::FRQ_1MHZ;
					end
				end
			end
			ioc_pkg::ST_RUN:
			begin
				if (newOsc_reg != active_reg)
					state_next = ioc_pkg::ST_SWITCH;
			end
			ioc_pkg::ST_SWITCH:
			begin
				// switch lands on the first tick of the target source
				if ((targetHf && hfTick) || (!targetHf && lfTick))
				begin
					active_next = newOsc_reg;
					state_next = ioc_pkg::ST_RUN;
				end
			end
			default: state_next = ioc_pkg::ST_BOOT;
		endcase
		if (wrStrobe && state_reg != ioc_pkg::ST_BOOT)
		begin
			case (addr)
				ioc_pkg::OFS_CTRL1:
				begin
					if (selValid)
						newOsc_next = wrData[6:4];
					new_divider_select_next = wrData[3:0];
				end
				ioc_pkg::OFS_FREQ: freq_next = wrData[3:0];
				ioc_pkg::OFS_TRIM: trim_next = wrData[5:0];
				ioc_pkg::OFS_EN: convEn_next = wrData[ioc_pkg::EN_CONV_BIT];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_reg <= ioc_pkg::ST_BOOT;
			bootCnt_reg <= 2'h0;
			newOsc_reg <= ioc_pkg::SEL_HF_1M;
			active_reg <= ioc_pkg::SEL_HF_1M;
			new_divider_select_reg <= ioc_pkg::NEW_DIVIDER_SELECT_RESET;
			freq_reg <= ioc_pkg::FRQ_1MHZ;
			trim_reg <= ioc_pkg::TRIM_RESET;
			convEn_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			bootCnt_reg <= bootCnt_next;
			newOsc_reg <= newOsc_next;
			active_reg <= active_next;
			new_divider_select_reg <= new_divider_select_next;
			freq_reg <= freq_next;
			trim_reg <= trim_next;
			convEn_reg <= convEn_next;
		end
	end

	// read path, data one cycle after the strobe; unmapped reads zero
	always_comb
	begin
		rd_next = '0;
		if (rdStrobe)
		begin
			case (addr)
				ioc_pkg::OFS_CTRL1: rd_next = {1'b0, newOsc_reg, new_divider_select_reg};
				ioc_pkg::OFS_FREQ: rd_next = {4'h0, freq_reg};
				ioc_pkg::OFS_TRIM: rd_next = {2'h0, trim_reg};
				ioc_pkg::OFS_EN:
					rd_next[ioc_pkg::EN_CONV_BIT] = convEn_reg;
				ioc_pkg::OFS_STAT:
				begin
					rd_next[2:0] = active_reg;
					rd_next[ioc_pkg::STAT_BUSY_BIT] =
						(state_reg != ioc_pkg::ST_RUN);
					rd_next[ioc_pkg::STAT_CONV_BIT] = converterOscRun;
				end
				default: rd_next = '0;
			endcase
		end
	end

	// system tick comes only from hf post divider or lf; mid ticks excluded
	always_comb
	begin
		sysTick_next = onHf ? postTick : lfTick;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			rd_reg <= '0;
			sysTick_reg <= 1'b0;
			lfTick_reg <= 1'b0;
		end
		else
		begin
			rd_reg <= rd_next;
			sysTick_reg <= sysTick_next;
			lfTick_reg <= lfTick;
		end
	end

	ioc_divider #(.WIDTH(ioc_pkg::DIV_W)) postDiv (
		.clock(clock),
		.rst(rst),
		.tickIn(hfTick),
		.ratio(postRatio),
		.tickOut(postTick)
	);

	// ratios follow the hf code so the mid rates stay fixed
	ioc_divider #(.WIDTH(ioc_pkg::DIV_W)) mid500Div (
		.clock(clock),
		.rst(rst),
		.tickIn(hfTick),
		.ratio(ioc_pkg::ratio500k(freqClamp)),
		.tickOut(mfTick500k)
	);

	ioc_divider #(.WIDTH(ioc_pkg::DIV_W)) mid31Div (
		.clock(clock),
		.rst(rst),
		.tickIn(hfTick),
		.ratio(ioc_pkg::ratio31k(freqClamp)),
		.tickOut(mfTick31k)
	);

	// trim steers hf only; lf tick path has no trim input
	ioc_trim_slew #(.STEP_CYC(ioc_pkg::TRIM_STEP_CYC)) trimSlew (
		.clock(clock),
		.rst(rst),
		.target(trim_reg),
		.level(hfTrimLevel)
	);

	assign rdData = rd_reg;
	assign hfFreqSelect = freqClamp;
	assign sysClkTick = sysTick_reg;
	assign activeOsc = active_reg;
	assign lfSlowTick = lfTick_reg;
	// converter oscillator is a fixed 600 kHz macro; only its run is ours
	assign converterOscRun = convEn_reg || converterSelectsRc;

	AST_BOOT_1M: assert property (@(posedge clock) disable iff (rst)
		(state_reg == ioc_pkg::ST_BOOT && state_next == ioc_pkg::ST_RUN
		&& strapSync_reg == ioc_pkg::SEL_HF_1M) |=>
		(hfFreqSelect == ioc_pkg::FRQ_1MHZ
		&& activeOsc == ioc_pkg::SEL_HF_1M))
		else $error("strap 110 did not start hf at 1 MHz");
	AST_BOOT_64M: assert property (@(posedge clock) disable iff (rst)
		(state_reg == ioc_pkg::ST_BOOT && state_next == ioc_pkg::ST_RUN
		&& strapSync_reg == ioc_pkg::SEL_HF_64M) |=>
		(hfFreqSelect == ioc_pkg::FRQ_64MHZ))
		else $error("strap 000 did not start hf at 64 MHz");
	AST_SWITCH: assert property (@(posedge clock) disable iff (rst)
		(wrStrobe && addr == ioc_pkg::OFS_CTRL1 && selValid
		&& state_reg == ioc_pkg::ST_RUN && wrData[6:4] != activeOsc) |=>
		##1 (state_reg == ioc_pkg::ST_SWITCH))
		else $error("select write did not start a switch");
	AST_FREQ_CAP: assert property (@(posedge clock) disable iff (rst)
		hfFreqSelect <= ioc_pkg::FRQ_CODE_MAX)
		else $error("hf frequency code above the 64 MHz setting");
	AST_FREQ_WRITE: assert property (@(posedge clock)
		disable iff (rst)
		(wrStrobe && addr == ioc_pkg::OFS_FREQ && state_reg != ioc_pkg::ST_BOOT
		&& wrData[3:0] <= ioc_pkg::FRQ_CODE_MAX) |=>
		(hfFreqSelect == $past(wrData[3:0])))
		else $error("frequency write not applied");
	AST_DIV_RANGE: assert property (@(posedge clock)
		disable iff (rst)
		postRatio >= 12'h001 && postRatio <= 12'h200)
		else $error("post divider ratio out of 1 to 512");
	AST_SYS_SRC: assert property (@(posedge clock) disable iff (rst)
		sysClkTick |-> $past(onHf ? postTick : lfTick))
		else $error("system tick from a source other than hf or lf");
	AST_TRIM_RD: assert property (@(posedge clock) disable iff (rst)
		(rdStrobe && addr == ioc_pkg::OFS_TRIM) |=>
		(rdData == {2'h0, $past(trim_reg)}))
		else $error("trim read mismatch");
	AST_CONV_AUTO: assert property (@(posedge clock)
		disable iff (rst)
		(converterSelectsRc || convEn_reg) |-> converterOscRun)
		else $error("converter oscillator not running when required");
	AST_CONV_OFF: assert property (@(posedge clock)
		disable iff (rst)
		(!converterSelectsRc && !convEn_reg) |-> !converterOscRun)
		else $error("converter oscillator running without cause");

	COV_SWITCH_LF: cover property (@(posedge clock) disable iff (rst)
		state_reg == ioc_pkg::ST_SWITCH ##[1:200] activeOsc == ioc_pkg::SEL_LF);
	COV_MID31: cover property (@(posedge clock) disable iff (rst) mfTick31k);
	COV_TRIM_MIN: cover property (@(posedge clock) disable iff (rst)
		trim_reg == 6'h20);
endmodule
`default_nettype wire

// *** hdl/ioc_pkg.sv ***
// constants, register map and encodings of the internal oscillator control
// assumes one 50 MHz clock and a synchronous active-high reset
`default_nettype none
package ioc_pkg;
	localparam int ADDR_W = 3;
	localparam int DATA_W = 8;
	localparam int DIV_W = 12;
	// register offsets
	localparam logic [2:0] OFS_CTRL1 = 3'h0;
	localparam logic [2:0] OFS_FREQ = 3'h1;
	localparam logic [2:0] OFS_TRIM = 3'h2;
	localparam logic [2:0] OFS_EN = 3'h3;
	localparam logic [2:0] OFS_STAT = 3'h4;
	// field positions
	localparam int CTRL1_NEW_DIVIDER_SELECT_LSB = 0;
	localparam int CTRL1_NEW_OSC_SELECT_LSB = 4;
	localparam int EN_CONV_BIT = 2;
	localparam int STAT_ACT_LSB = 0;
	localparam int STAT_BUSY_BIT = 3;
	localparam int STAT_CONV_BIT = 4;
	// oscillator select codes
	localparam logic [2:0] SEL_HF_1M = 3'h6;
	localparam logic [2:0] SEL_HF_64M = 3'h0;
	localparam logic [2:0] SEL_LF = 3'h5;
	// frequency and divider codes
	localparam logic [3:0] FRQ_1MHZ = 4'h0;
	localparam logic [3:0] FRQ_64MHZ = 4'h8;
	localparam logic [3:0] FRQ_CODE_MAX = 4'h8;
	localparam logic [3:0] NEW_DIVIDER_SELECT_MAX = 4'h9;
	localparam logic [3:0] NEW_DIVIDER_SELECT_RESET = 4'h0;
	localparam logic [5:0] TRIM_RESET = 6'h00;
	localparam logic [1:0] BOOT_WAIT = 2'h2;
	// trim slew timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int TRIM_STEP_NS = 1000;
	localparam int TRIM_STEP_CYC =
		(TRIM_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [1:0] {
		ST_BOOT = 2'h0,
		ST_RUN = 2'h1,
		ST_SWITCH = 2'h3
	} ioc_state_e;

	// hf code -> MHz: 1,2,4,8,12,16,32,48,64
	function automatic logic [DIV_W-1:0] ratio500k(input logic [3:0] code);
		case (code)
			4'h0: ratio500k = 12'h002;
			4'h1: ratio500k = 12'h004;
			4'h2: ratio500k = 12'h008;
			4'h3: ratio500k = 12'h010;
			4'h4: ratio500k = 12'h018;
			4'h5: ratio500k = 12'h020;
			4'h6: ratio500k = 12'h040;
			4'h7: ratio500k = 12'h060;
			default: ratio500k = 12'h080;
		endcase
	endfunction

	// 31.25 kHz is 500 kHz divided by sixteen
	function automatic logic [DIV_W-1:0] ratio31k(input logic [3:0] code);
		ratio31k = DIV_W'(ratio500k(code) << 4);
	endfunction
endpackage
`default_nettype wire

// *** hdl/ioc_trim_slew.sv ***
// moves the applied trim level one step at a time toward the target
// assumes target comes from a register on the same clock
`default_nettype none
module ioc_trim_slew #(
	parameter int STEP_CYC = 50
) (
	input wire logic clock,
	input wire logic rst,
	input wire logic signed [5:0] target,
	output logic signed [5:0] level
);
	logic signed [5:0] level_reg;
	logic signed [5:0] level_next;
	logic [15:0] cnt_reg;
	logic [15:0] cnt_next;

	always_comb
	begin
		level_next = level_reg;
		cnt_next = cnt_reg;
		if (level_reg == target)
			cnt_next = '0;
		else if (cnt_reg >= 16'(STEP_CYC - 1))
		begin
			cnt_next = '0;
			if (target > level_reg)
				level_next = level_reg + 6'sd1;
			else
				level_next = level_reg - 6'sd1;
		end
		else
			cnt_next = cnt_reg + 16'h0001;
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			level_reg <= '0;
			cnt_reg <= '0;
		end
		else
		begin
			level_reg <= level_next;
			cnt_reg <= cnt_next;
		end
	end

	assign level = level_reg;

	AST_TRIM_GRADUAL: assert property (@(posedge clock)
		disable iff (rst)
		$changed(level) |-> ($past(level) - level == 6'sd1
		|| level - $past(level) == 6'sd1))
		else $error("trim level jumped by more than one step");
endmodule
`default_nettype wire

// *** tb/ioc_osc_control_test.sv ***
// self-checking bench of the internal oscillator control
// assumes hdl/ioc_pkg.sv and the design modules are compiled first
`default_nettype none
module ioc_osc_control_test;
	timeunit 1ns;
	timeprecision 1ns;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic [2:0] resetOscSelect = 3'h6;
	logic hfTick = 1'b0;
	logic lfTick = 1'b0;
	logic converterSelectsRc = 1'b0;
	logic [ioc_pkg::ADDR_W-1:0] addr = 3'h0;
	logic [ioc_pkg::DATA_W-1:0] wrData = 8'h00;
	logic wrStrobe = 1'b0;
	logic rdStrobe = 1'b0;
	logic [ioc_pkg::DATA_W-1:0] rdData;
	logic [3:0] hfFreqSelect;
	logic signed [5:0] hfTrimLevel;
	logic sysClkTick;
	logic [2:0] activeOsc;
	logic lfSlowTick;
	logic mfTick500k;
	logic mfTick31k;
	logic converterOscRun;
	int failures = 0;
	int checked = 0;
	int gapLen;
	int ratio [9] = '{2, 4, 8, 16, 24, 32, 64, 96, 128};
	int divCode [4] = '{0, 3, 9, 15};
	logic [7:0] rv;

	ioc_osc_control dut_u (
		.clock(clock),
		.rst(rst),
		.resetOscSelect(resetOscSelect),
		.hfTick(hfTick),
		.lfTick(lfTick),
		.converterSelectsRc(converterSelectsRc),
		.addr(addr),
		.wrData(wrData),
		.wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe),
		.rdData(rdData),
		.hfFreqSelect(hfFreqSelect),
		.hfTrimLevel(hfTrimLevel),
		.sysClkTick(sysClkTick),
		.activeOsc(activeOsc),
		.lfSlowTick(lfSlowTick),
		.mfTick500k(mfTick500k),
		.mfTick31k(mfTick31k),
		.converterOscRun(converterOscRun)
	);

	always #10 clock = ~clock;

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// one idle cycle after each strobe keeps every assignment in its own step
	task automatic wr(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wrData <= d;
		wrStrobe <= 1'b1;
		@(posedge clock);
		wrStrobe <= 1'b0;
	endtask

	task automatic rd(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock);
		addr <= a;
		rdStrobe <= 1'b1;
		@(posedge clock);
		rdStrobe <= 1'b0;
		// data stands until the next edge; sample it settled
		@(negedge clock);
		d = rdData;
	endtask

	task automatic lfPulse();
		@(posedge clock);
		lfTick <= 1'b1;
		@(posedge clock);
		lfTick <= 1'b0;
		@(posedge clock);
		check(lfSlowTick, 1'b1);
	endtask

	function automatic logic pick(input int s);
		case (s)
			0: pick = sysClkTick;
			1: pick = mfTick500k;
			default: pick = mfTick31k;
		endcase
	endfunction

	// skips two pulses since the interval right after a ratio change is odd
	task automatic gap(input int s, output int n);
		int k;
		k = 0;
		repeat (2)
		begin
			do
			begin
				@(posedge clock);
				k++;
			end
			while (pick(s) !== 1'b1 && k < 9000);
		end
		n = 0;
		do
		begin
			@(posedge clock);
			n++;
		end
		while (pick(s) !== 1'b1 && n < 9000);
	endtask

	initial
	begin
		repeat (40000) @(posedge clock);
		failures++;
		complete_run();
	end

	initial
	begin
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		hfTick <= 1'b1;
		repeat (6) @(posedge clock);
		rd(ioc_pkg::OFS_STAT, rv);
		check(rv, 8'h06);
		check(hfFreqSelect, 4'h0);
		rd(ioc_pkg::OFS_TRIM, rv);
		check(rv, 8'h00);
		wr(ioc_pkg::OFS_TRIM, 8'h1f);
		@(posedge clock);
		check(hfTrimLevel === 6'sh1f, 1'b0);
		repeat (1700) @(posedge clock);
		check($unsigned(hfTrimLevel), 6'h1f);
		rd(ioc_pkg::OFS_TRIM, rv);
		check(rv, 8'h1f);
		wr(ioc_pkg::OFS_TRIM, 8'h20);
		repeat (3300) @(posedge clock);
		check($unsigned(hfTrimLevel), 6'h20);
		rd(ioc_pkg::OFS_TRIM, rv);
		check(rv, 8'h20);
		lfPulse();
		for (int c = 0; c < 16; c++)
		begin
			wr(ioc_pkg::OFS_FREQ, 8'(c));
			@(posedge clock);
			check(hfFreqSelect, (c > 8) ? 8 : c);
			rd(ioc_pkg::OFS_FREQ, rv);
			check(rv, 8'(c));
			if (c < 9)
			begin
				gap(1, gapLen);
				check(gapLen, ratio[c]);
			end
		end
		wr(ioc_pkg::OFS_FREQ, 8'h00);
		gap(2, gapLen);
		check(gapLen, 32);
		wr(ioc_pkg::OFS_FREQ, 8'h02);
		gap(2, gapLen);
		check(gapLen, 128);
		foreach (divCode[i])
		begin
			wr(ioc_pkg::OFS_CTRL1, 8'h60 | 8'(divCode[i]));
			gap(0, gapLen);
			check(gapLen, 1 << ((divCode[i] > 9) ? 9 : divCode[i]));
		end
		// lf switch waits for the first lf tick, so the source stays hf meanwhile
		wr(ioc_pkg::OFS_CTRL1, 8'h50);
		repeat (3) @(posedge clock);
		check(activeOsc, 3'h6);
		rd(ioc_pkg::OFS_STAT, rv);
		check(rv, 8'h0e);
		lfPulse();
		repeat (2) @(posedge clock);
		check(activeOsc, 3'h5);
		rd(ioc_pkg::OFS_STAT, rv);
		check(rv, 8'h05);
		wr(ioc_pkg::OFS_CTRL1, 8'h20);
		repeat (3) @(posedge clock);
		// mid ticks keep running here, yet the system tick stays quiet
		check(sysClkTick, 1'b0);
		lfPulse();
		repeat (2) @(posedge clock);
		check(activeOsc, 3'h5);
		wr(ioc_pkg::OFS_CTRL1, 8'h60);
		repeat (6) @(posedge clock);
		check(activeOsc, 3'h6);
		wr(ioc_pkg::OFS_EN, 8'h04);
		@(posedge clock);
		check(converterOscRun, 1'b1);
		rd(ioc_pkg::OFS_STAT, rv);
		check(rv, 8'h16);
		wr(ioc_pkg::OFS_EN, 8'h00);
		@(posedge clock);
		check(converterOscRun, 1'b0);
		converterSelectsRc <= 1'b1;
		@(posedge clock);
		@(posedge clock);
		check(converterOscRun, 1'b1);
		converterSelectsRc <= 1'b0;
		@(posedge clock);
		@(posedge clock);
		check(converterOscRun, 1'b0);
		rd(3'h5, rv);
		check(rv, 8'h00);
		wr(3'h7, 8'hff);
		rd(3'h7, rv);
		check(rv, 8'h00);
		rd(ioc_pkg::OFS_FREQ, rv);
		check(rv, 8'h02);
		// second reset with the other strap; trim must return to zero
		@(posedge clock);
		resetOscSelect <= 3'h0;
		rst <= 1'b1;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		repeat (6) @(posedge clock);
		check(activeOsc, 3'h0);
		check(hfFreqSelect, 4'h8);
		rd(ioc_pkg::OFS_STAT, rv);
		check(rv, 8'h00);
		rd(ioc_pkg::OFS_TRIM, rv);
		check(rv, 8'h00);
		// 110 from 000 stays on hf and keeps the frequency
		wr(ioc_pkg::OFS_CTRL1, 8'h60);
		repeat (6) @(posedge clock);
		check(activeOsc, 3'h6);
		check(hfFreqSelect, 4'h8);
		// lf strap boots straight onto the low oscillator
		@(posedge clock);
		resetOscSelect <= 3'h5;
		rst <= 1'b1;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		repeat (6) @(posedge clock);
		check(activeOsc, 3'h5);
		complete_run();
	end
endmodule
`default_nettype wire
